/* File: pkg/icb_pkg.sv */
// constants, types and register map of the interrupt pulse counter block
// -----------------------------------------------------------------------
// -----------------------------------------------------------------------
package icb_pkg;
   localparam int ICB_ADDR_W = 8;
   localparam int ICB_PINS = 8;
   localparam int ICB_QBITS = 4;

   // register offsets
   localparam logic [7:0] ICB_REG_CTRL = 8'h00;
   localparam logic [7:0] ICB_REG_SETPOINT = 8'h04;
   localparam logic [7:0] ICB_REG_COUNT = 8'h08;
   localparam logic [7:0] ICB_REG_FREQ = 8'h0C;
   localparam logic [7:0] ICB_REG_QBITS = 8'h10;
   localparam logic [7:0] ICB_REG_STATUS = 8'h14;

   // control field layout
   localparam int ICB_MODE_LSB = 0;
   localparam int ICB_EN_EVAL_BIT = 3;
   localparam int ICB_IVAL_LSB = 4;
   localparam int ICB_SRCA_LSB = 8;
   localparam int ICB_SRCB_LSB = 12;

   // measuring intervals, clock 20 MHz
   localparam int ICB_CLK_MHZ = 20;
   localparam int ICB_IVAL0_US = 10000;
   localparam int ICB_IVAL1_US = 100000;
   localparam int ICB_IVAL2_US = 1000000;
   localparam int ICB_IVAL0_CYC = ICB_IVAL0_US * ICB_CLK_MHZ;
   localparam int ICB_IVAL1_CYC = ICB_IVAL1_US * ICB_CLK_MHZ;
   localparam int ICB_IVAL2_CYC = ICB_IVAL2_US * ICB_CLK_MHZ;
   // pulses per interval times scale gives hertz
   localparam logic [31:0] ICB_SCALE0 = 32'h0000_0064;
   localparam logic [31:0] ICB_SCALE1 = 32'h0000_000A;
   localparam logic [31:0] ICB_SCALE2 = 32'h0000_0001;

   typedef enum logic [2:0] {
      ICB_EXT_DIR,
      ICB_DUAL,
      ICB_QUAD,
      ICB_FREQ_OVER,
      ICB_FREQ_UNDER
   } icb_mode_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } icb_bus_req_t;

   typedef struct packed {
      logic [7:0] sy1;
      logic [7:0] sy2;
      logic [7:0] sy3;
      icb_mode_t mode;
      logic en_eval;
      logic [1:0] ival;
      logic [2:0] src_a;
      logic [2:0] src_b;
      logic [31:0] sv;
      logic [31:0] count;
      logic [31:0] freq;
      logic [31:0] gate;
      logic [31:0] pulses;
      logic hit;
      logic trig;
      logic flag;
      logic [3:0] qbits;
      logic [31:0] rdata;
   } icb_state_t;
endpackage

/* File: src/icb_counter.sv */
// interrupt pulse counter: counting, frequency compare and register port
`timescale 1ns/1ps
module icb_counter #(
   parameter int unsigned IVAL0_CYC = icb_pkg::ICB_IVAL0_CYC,
   parameter int unsigned IVAL1_CYC = icb_pkg::ICB_IVAL1_CYC,
   parameter int unsigned IVAL2_CYC = icb_pkg::ICB_IVAL2_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_pins,
   input wire logic i_enable,
   input wire logic i_clear,
   input wire icb_pkg::icb_bus_req_t i_bus,
   output logic [31:0] o_rdata,
   output logic [31:0] o_count_value,
   output logic o_trigger,
   output logic [3:0] o_handler_bits
);
   import icb_pkg::*;

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   icb_state_t r;
   icb_state_t n;
   logic [7:0] rise;
   logic [7:0] fall;
   logic a_lvl;
   logic b_lvl;
   logic a_edge;
   logic run;
   logic cnt_mode;
   logic [1:0] delta;
   logic [31:0] step;
   logic [31:0] len;
   logic [31:0] scale;
   logic [31:0] ptot;
   logic cond;
   logic fire;

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      n = r;
      // two stages before any logic, third stage only for edge detect
      n.sy1 = i_pins;
      n.sy2 = r.sy1;
      n.sy3 = r.sy2;
      rise = r.sy2 & ~r.sy3;
      fall = ~r.sy2 & r.sy3;
      a_lvl = r.sy2[r.src_a];
      b_lvl = r.sy2[r.src_b];
      a_edge = rise[r.src_a] | fall[r.src_a];
      // sampling at 20 MHz leaves ample margin for 5 kHz pulse trains
      run = ~r.en_eval | i_enable;
      cnt_mode = (r.mode == ICB_EXT_DIR) || (r.mode == ICB_DUAL) || (r.mode == ICB_QUAD);
      fire = 1'b0;
      cond = 1'b0;

      // signed step of -1, 0 or +1 per clock
      delta = 2'b00;
      case (r.mode)
         ICB_EXT_DIR: begin
            if (rise[r.src_a]) begin
               delta = b_lvl ? 2'b11 : 2'b01;
            end
         end
         ICB_DUAL: begin
            // simultaneous up and down pulses cancel
            if (rise[r.src_a] && !rise[r.src_b]) begin
               delta = 2'b01;
            end else if (rise[r.src_b] && !rise[r.src_a]) begin
               delta = 2'b11;
            end
         end
         ICB_QUAD: begin
            // both A edges count, so one full period moves the count by two
            if (a_edge) begin
               delta = (a_lvl != b_lvl) ? 2'b01 : 2'b11;
            end
         end
         default: begin
            delta = 2'b00;
         end
      endcase
      step = {{30{delta[1]}}, delta};

      // count update, clear has priority over counting
      if (run) begin
         n.count = r.count + step;
      end
      if (i_clear) begin
         n.count = 32'h0000_0000;
      end
      if (cnt_mode && run && !i_clear && (delta != 2'b00)
          && ($signed(n.count) == $signed(r.sv))) begin
         fire = 1'b1;
      end

      // frequency measurement
      len = IVAL2_CYC;
      scale = ICB_SCALE2;
      case (r.ival)
         2'b00: begin
            len = IVAL0_CYC;
            scale = ICB_SCALE0;
         end
         2'b01: begin
            len = IVAL1_CYC;
            scale = ICB_SCALE1;
         end
         default: begin
            len = IVAL2_CYC;
            scale = ICB_SCALE2;
         end
      endcase
      ptot = r.pulses + {31'h0000_0000, rise[r.src_a]};
      if (cnt_mode || !run) begin
         n.gate = 32'h0000_0000;
         n.pulses = 32'h0000_0000;
         n.hit = 1'b0;
      end else if (r.gate >= len - 32'h0000_0001) begin
         n.gate = 32'h0000_0000;
         n.pulses = 32'h0000_0000;
         n.freq = 32'(ptot * scale);
         if (r.mode == ICB_FREQ_OVER) begin
            cond = $signed(n.freq) > $signed(r.sv);
         end else begin
            cond = $signed(n.freq) < $signed(r.sv);
         end
         // fire once on entering the condition, not every interval
         fire = cond && !r.hit;
         n.hit = cond;
      end else begin
         n.gate = r.gate + 32'h0000_0001;
         n.pulses = ptot;
      end
      n.trig = fire;

      // -----------------------------------------------------------------
      // register port
      // -----------------------------------------------------------------
      n.rdata = 32'h0000_0000;
      if (i_bus.wr) begin
         if (i_bus.addr == ICB_REG_CTRL) begin
            n.mode = icb_mode_t'(i_bus.wdata[ICB_MODE_LSB +: 3]);
            n.en_eval = i_bus.wdata[ICB_EN_EVAL_BIT];
            n.ival = i_bus.wdata[ICB_IVAL_LSB +: 2];
            n.src_a = i_bus.wdata[ICB_SRCA_LSB +: 3];
            n.src_b = i_bus.wdata[ICB_SRCB_LSB +: 3];
            // new setup restarts any running measurement
            n.gate = 32'h0000_0000;
            n.pulses = 32'h0000_0000;
            n.hit = 1'b0;
         end else if (i_bus.addr == ICB_REG_SETPOINT) begin
            n.sv = i_bus.wdata;
         end else if (i_bus.addr == ICB_REG_QBITS) begin
            n.qbits = i_bus.wdata[3:0];
         end else if (i_bus.addr == ICB_REG_STATUS) begin
            if (i_bus.wdata[0]) begin
               n.flag = 1'b0;
            end
         end
      end
      // a trigger in the clearing cycle is kept
      if (fire) begin
         n.flag = 1'b1;
      end
      if (i_bus.rd) begin
         if (i_bus.addr == ICB_REG_CTRL) begin
            n.rdata[ICB_MODE_LSB +: 3] = r.mode;
            n.rdata[ICB_EN_EVAL_BIT] = r.en_eval;
            n.rdata[ICB_IVAL_LSB +: 2] = r.ival;
            n.rdata[ICB_SRCA_LSB +: 3] = r.src_a;
            n.rdata[ICB_SRCB_LSB +: 3] = r.src_b;
         end else if (i_bus.addr == ICB_REG_SETPOINT) begin
            n.rdata = r.sv;
         end else if (i_bus.addr == ICB_REG_COUNT) begin
            n.rdata = r.count;
         end else if (i_bus.addr == ICB_REG_FREQ) begin
            n.rdata = r.freq;
         end else if (i_bus.addr == ICB_REG_QBITS) begin
            n.rdata[3:0] = r.qbits;
         end else if (i_bus.addr == ICB_REG_STATUS) begin
            n.rdata[0] = r.flag;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign o_rdata = r.rdata;
   assign o_count_value = r.count;
   assign o_trigger = r.trig;
   assign o_handler_bits = r.qbits;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   property p_clear;
      @(posedge i_clk) disable iff (i_rst)
      i_clear |=> (r.count == 32'h0000_0000);
   endproperty
   a_clear: assert property (p_clear) else $error("count not cleared");

   property p_ext_up;
      @(posedge i_clk) disable iff (i_rst)
      (r.mode == ICB_EXT_DIR && run && !i_clear && rise[r.src_a] && !b_lvl)
      |=> (r.count == $past(r.count) + 32'h0000_0001);
   endproperty
   a_ext_up: assert property (p_ext_up) else $error("ext up step wrong");

   property p_ext_down;
      @(posedge i_clk) disable iff (i_rst)
      (r.mode == ICB_EXT_DIR && run && !i_clear && rise[r.src_a] && b_lvl)
      |=> (r.count == $past(r.count) - 32'h0000_0001);
   endproperty
   a_ext_down: assert property (p_ext_down) else $error("ext down step wrong");

   property p_dual_down;
      @(posedge i_clk) disable iff (i_rst)
      (r.mode == ICB_DUAL && run && !i_clear && rise[r.src_b] && !rise[r.src_a])
      |=> (r.count == $past(r.count) - 32'h0000_0001);
   endproperty
   a_dual_down: assert property (p_dual_down) else $error("dual down wrong");

   property p_quad;
      @(posedge i_clk) disable iff (i_rst)
      (r.mode == ICB_QUAD && run && !i_clear && a_edge && (a_lvl != b_lvl))
      |=> (r.count == $past(r.count) + 32'h0000_0001);
   endproperty
   a_quad: assert property (p_quad) else $error("quad up step wrong");

   property p_gate;
      @(posedge i_clk) disable iff (i_rst)
      (r.en_eval && !i_enable && !i_clear) |=> (r.count == $past(r.count));
   endproperty
   a_gate: assert property (p_gate) else $error("count moved while disabled");

   // judged against the mode and setpoint of the deciding cycle, a setup write may land with it
   property p_reach;
      @(posedge i_clk) disable iff (i_rst)
      (o_trigger && $past(cnt_mode))
      |-> (r.count == $past(r.sv)) && ($past(r.count) != r.count);
   endproperty
   a_reach: assert property (p_reach) else $error("trigger without reach");

   property p_over;
      @(posedge i_clk) disable iff (i_rst)
      (o_trigger && $past(r.mode) == ICB_FREQ_OVER) |-> ($signed(r.freq) > $signed($past(r.sv)));
   endproperty
   a_over: assert property (p_over) else $error("over trigger wrong");

   property p_under;
      @(posedge i_clk) disable iff (i_rst)
      (o_trigger && $past(r.mode) == ICB_FREQ_UNDER) |-> ($signed(r.freq) < $signed($past(r.sv)));
   endproperty
   a_under: assert property (p_under) else $error("under trigger wrong");

   property p_interval;
      @(posedge i_clk) disable iff (i_rst)
      (r.gate < len);
   endproperty
   a_interval: assert property (p_interval) else $error("gate overran");

   property p_qbits;
      @(posedge i_clk) disable iff (i_rst)
      (i_bus.wr && i_bus.addr == ICB_REG_QBITS) |=> (o_handler_bits == $past(i_bus.wdata[3:0]));
   endproperty
   a_qbits: assert property (p_qbits) else $error("handler bits not written");

   property p_dual_up;
      @(posedge i_clk) disable iff (i_rst)
      (r.mode == ICB_DUAL && run && !i_clear && rise[r.src_a] && !rise[r.src_b])
      |=> (r.count == $past(r.count) + 32'h0000_0001);
   endproperty
   a_dual_up: assert property (p_dual_up) else $error("dual up wrong");

   property p_quad_down;
      @(posedge i_clk) disable iff (i_rst)
      (r.mode == ICB_QUAD && run && !i_clear && a_edge && (a_lvl == b_lvl))
      |=> (r.count == $past(r.count) - 32'h0000_0001);
   endproperty
   a_quad_down: assert property (p_quad_down) else $error("quad down step wrong");

   property p_freq_hold;
      @(posedge i_clk) disable iff (i_rst)
      (!cnt_mode && !i_clear) |=> (r.count == $past(r.count));
   endproperty
   a_freq_hold: assert property (p_freq_hold) else $error("count moved in freq mode");

   property p_clear_quiet;
      @(posedge i_clk) disable iff (i_rst)
      (i_clear && cnt_mode) |=> !o_trigger;
   endproperty
   a_clear_quiet: assert property (p_clear_quiet) else $error("clear raised trigger");

   property p_rd_count;
      @(posedge i_clk) disable iff (i_rst)
      (i_bus.rd && i_bus.addr == ICB_REG_COUNT) |=> (o_rdata == $past(r.count));
   endproperty
   a_rd_count: assert property (p_rd_count) else $error("count read wrong");

   property p_rd_qbits;
      @(posedge i_clk) disable iff (i_rst)
      (i_bus.rd && i_bus.addr == ICB_REG_QBITS) |=> (o_rdata[3:0] == $past(r.qbits));
   endproperty
   a_rd_qbits: assert property (p_rd_qbits) else $error("handler bits read wrong");

   property p_flag;
      @(posedge i_clk) disable iff (i_rst)
      fire |=> r.flag;
   endproperty
   a_flag: assert property (p_flag) else $error("trigger flag not set");

   property p_qbits_hold;
      @(posedge i_clk) disable iff (i_rst)
      !(i_bus.wr && i_bus.addr == ICB_REG_QBITS) |=> $stable(o_handler_bits);
   endproperty
   a_qbits_hold: assert property (p_qbits_hold) else $error("handler bits moved");

   property p_edge_once;
      @(posedge i_clk) disable iff (i_rst)
      (rise != 8'h00) |=> ((rise & $past(rise)) == 8'h00);
   endproperty
   a_edge_once: assert property (p_edge_once) else $error("input edge seen twice");

   property p_sync;
      @(posedge i_clk) disable iff (i_rst)
      (r.sy2 == $past(r.sy1)) && (r.sy3 == $past(r.sy2));
   endproperty
   a_sync: assert property (p_sync) else $error("synchroniser stage skipped");

endmodule // icb_counter

/* File: sim/icb_pulse_src.sv */
// pulse source and quadrature encoder model driving the device inputs
`timescale 1ns/1ps
module icb_pulse_src (
   input wire logic i_clk,
   output logic [7:0] o_pins
);
   // each level is held four cycles, twice what the input synchroniser needs
   initial o_pins = 8'h00;

   task automatic level(input int idx, input logic val);
      o_pins[idx] <= val;
      repeat (4) @(posedge i_clk);
   endtask

   task automatic pulse(input int idx);
      level(idx, 1'b1);
      level(idx, 1'b0);
   endtask

   // one full period, channels ninety degrees apart; up means a leads b
   task automatic quad(input int a, input int b, input logic up);
      if (up) begin
         level(a, 1'b1);
         level(b, 1'b1);
         level(a, 1'b0);
         level(b, 1'b0);
      end else begin
         level(b, 1'b1);
         level(a, 1'b1);
         level(b, 1'b0);
         level(a, 1'b0);
      end
   endtask
endmodule // icb_pulse_src

/* File: sim/tb_top.sv */
// self-checking testbench of the interrupt pulse counter block
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
   import icb_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_enable = 1'b0;
   logic i_clear = 1'b0;
   icb_bus_req_t bus = '0;
   logic [7:0] pins;
   logic [31:0] rdata, count;
   logic trig;
   logic [3:0] hbits;
   int miscompares = 0;
   int tests_run = 0;
   int trig_cnt = 0;
   int t0;
   logic [31:0] d;

   always #25 i_clk = ~i_clk;
   always @(posedge i_clk) if (trig === 1'b1) trig_cnt++;

   icb_pulse_src i_src (.i_clk(i_clk), .o_pins(pins));
   // intervals shortened so a frequency result arrives within 400 to 1600 cycles
   icb_counter #(.IVAL0_CYC(400), .IVAL1_CYC(800), .IVAL2_CYC(1600)) i_dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_pins(pins), .i_enable(i_enable),
      .i_clear(i_clear), .i_bus(bus), .o_rdata(rdata), .o_count_value(count),
      .o_trigger(trig), .o_handler_bits(hbits));

   // ----------------------------------------
   // bus and helper tasks
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge i_clk);
      bus.wr <= 1'b0;
      @(posedge i_clk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge i_clk);
      bus.rd <= 1'b0;
      // read data stand only until the next edge
      #1 v = rdata;
      @(posedge i_clk);
   endtask

   task automatic cfg(input int mode, input int ev, input int iv, input int sa, input int sb,
                      input logic [31:0] sv);
      wr(ICB_REG_SETPOINT, sv);
      wr(ICB_REG_CTRL, 32'(mode) | 32'(ev) << ICB_EN_EVAL_BIT | 32'(iv) << ICB_IVAL_LSB
         | 32'(sa) << ICB_SRCA_LSB | 32'(sb) << ICB_SRCB_LSB);
      t0 = trig_cnt;
   endtask

   task automatic clr;
      i_clear <= 1'b1;
      @(posedge i_clk);
      i_clear <= 1'b0;
      repeat (2) @(posedge i_clk);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs;
      `CHK(count, 32'h0000_0000)
      rd(ICB_REG_CTRL, d);
      `CHK(d, 32'h0000_0000)
      wr(ICB_REG_QBITS, 32'h0000_000A);
      `CHK(hbits, 4'hA)
      rd(ICB_REG_QBITS, d);
      `CHK(d[3:0], 4'hA)
      rd(8'h40, d);
      `CHK(d, 32'h0000_0000)
      // the address bits that no register uses must not alias onto one
      rd(8'hA3, d);
      `CHK(d, 32'h0000_0000)
   endtask

   task automatic t_extdir;
      cfg(0, 0, 0, 0, 4, 32'h0000_0003);
      repeat (3) i_src.pulse(0);
      i_src.level(4, 1'b1);
      repeat (2) i_src.pulse(0);
      repeat (4) @(posedge i_clk);
      `CHK(count, 32'h0000_0001)
      rd(ICB_REG_COUNT, d);
      `CHK(d, 32'h0000_0001)
      `CHK(trig_cnt - t0, 1)
      rd(ICB_REG_STATUS, d);
      `CHK(d, 32'h0000_0001)
      wr(ICB_REG_STATUS, 32'h0000_0001);
      rd(ICB_REG_STATUS, d);
      `CHK(d, 32'h0000_0000)
      clr;
      `CHK(count, 32'h0000_0000)
      `CHK(trig_cnt - t0, 1)
   endtask

   task automatic t_dual;
      cfg(1, 0, 0, 1, 2, 32'hFFFF_FFFF);
      i_src.pulse(1);
      repeat (2) i_src.pulse(2);
      repeat (4) @(posedge i_clk);
      `CHK(count, 32'hFFFF_FFFF)
      `CHK(trig_cnt - t0, 1)
      wr(ICB_REG_COUNT, 32'h0000_0005);
      rd(ICB_REG_COUNT, d);
      `CHK(d, 32'hFFFF_FFFF)
      clr;
   endtask

   task automatic t_quad;
      cfg(2, 0, 0, 2, 3, 32'h0000_0004);
      repeat (2) i_src.quad(2, 3, 1'b1);
      repeat (4) @(posedge i_clk);
      `CHK(count, 32'h0000_0004)
      i_src.quad(2, 3, 1'b0);
      repeat (4) @(posedge i_clk);
      `CHK(count, 32'h0000_0002)
      `CHK(trig_cnt - t0, 1)
      clr;
   endtask

   task automatic t_enable;
      // pulse on input four, direction on input eight then input six, pin 8 high counts down
      i_src.level(7, 1'b1);
      cfg(0, 1, 0, 3, 7, 32'h0000_0064);
      i_src.pulse(3);
      repeat (4) @(posedge i_clk);
      `CHK(count, 32'h0000_0000)
      i_enable <= 1'b1;
      i_src.pulse(3);
      repeat (4) @(posedge i_clk);
      `CHK(count, 32'hFFFF_FFFF)
      cfg(0, 0, 0, 3, 5, 32'h0000_0064);
      i_enable <= 1'b0;
      i_src.pulse(3);
      repeat (4) @(posedge i_clk);
      `CHK(count, 32'h0000_0000)
      i_src.level(7, 1'b0);
      clr;
   endtask

   task automatic t_freq;
      // eight cycles a pulse: 50 per 400-cycle interval, 5000 Hz at scale 100
      cfg(3, 0, 0, 0, 4, 32'h0000_03E8);
      repeat (150) i_src.pulse(0);
      `CHK(trig_cnt - t0, 1)
      rd(ICB_REG_FREQ, d);
      `CHK(d > 32'h0000_12C0 && d < 32'h0000_1450, 1'b1)
      `CHK(count, 32'h0000_0000)
      // 100 per 800-cycle interval at scale 10 gives 1000 Hz
      cfg(4, 0, 1, 6, 4, 32'h0000_2328);
      repeat (250) i_src.pulse(6);
      `CHK(trig_cnt > t0, 1'b1)
      rd(ICB_REG_FREQ, d);
      `CHK(d > 32'h0000_0384 && d < 32'h0000_044C, 1'b1)
      // 200 per 1600-cycle interval at scale 1 gives 200 Hz
      cfg(3, 0, 2, 5, 4, 32'h0000_0064);
      repeat (400) i_src.pulse(5);
      `CHK(trig_cnt - t0, 1)
      rd(ICB_REG_FREQ, d);
      `CHK(d > 32'h0000_00BE && d < 32'h0000_00D2, 1'b1)
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (2) @(posedge i_clk);
      t_regs;
      t_extdir;
      t_dual;
      t_quad;
      t_enable;
      t_freq;
      end_sim;
   end

   // the scenarios take about 6700 cycles
   initial begin
      #(50 * 20000);
      miscompares++;
      end_sim;
   end
endmodule // tb_top
